// File: itt_regs.svh
// register offsets, field positions, reset values and timing counts
`ifndef ITT_REGS_SVH
`define ITT_REGS_SVH

// ----------------------------------------------------------------------
// offsets
// ----------------------------------------------------------------------
`define ITT_ADDR_W 4
`define ITT_OFS_IRQ_STATUS 4'h0
`define ITT_OFS_IRQ_MASK 4'h1
`define ITT_OFS_TIMER 4'hd
`define ITT_OFS_TXQ 4'he
`define ITT_OFS_RESET 4'hf

// ----------------------------------------------------------------------
// fields
// ----------------------------------------------------------------------
`define ITT_TIMER_INTERVAL_LSB 0
`define ITT_TIMER_USAGE_LSB 4
`define ITT_TXQ_UNDERRUN_BIT 5
`define ITT_RST_WHOLE_BIT 0
`define ITT_RST_RX_BIT 1
`define ITT_RST_TX_BIT 2
`define ITT_RST_BAD_CRC_BIT 4
`define ITT_IRQ_TIMEOUT_BIT 0
`define ITT_IRQ_UNDERRUN_BIT 1
`define ITT_IRQ_RX_EOF_BIT 2
`define ITT_IRQ_RX_FULL_BIT 3
`define ITT_IRQ_TX_DONE_BIT 4
`define ITT_IRQ_TX_EMPTY_BIT 5

// ----------------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------------
`define ITT_INTERVAL_RESET 4'hf
`define ITT_USAGE_PROG 4'h2
`define ITT_USAGE_OFF 4'h6
`define ITT_IRQ_MASK_RESET 6'h00
`define ITT_PRIO_MAX 4'hf

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define ITT_STEP_US 127000
`define ITT_CLK_MHZ 125
`define ITT_STEP_CYCLES (`ITT_STEP_US * `ITT_CLK_MHZ)

`endif

// File: itt_pkg.sv
// types shared by the timer and HDLC control register slice
package itt_pkg;

	typedef enum logic [1:0] {
		ITT_TMR_IDLE = 2'b01,
		ITT_TMR_RUN = 2'b10
	} itt_tmr_state_t;

	typedef struct packed {
		itt_tmr_state_t tmr_state;
		logic [3:0] interval;
		logic [3:0] usage;
		logic [23:0] prescale;
		logic [4:0] steps_left;
		logic timeout;
		logic underrun_abort_flag;
		logic [3:0] prio_count;
		logic force_bad_crc;
		logic whole_rst;
		logic rx_rst;
		logic tx_rst;
		logic [5:0] irq_status;
		logic [5:0] irq_mask;
		logic irq;
		logic [7:0] rd_data;
	} itt_state_t;

endpackage

// File: itt_ctrl.sv
// timer, transmit queue status and soft reset register slice
`include "itt_regs.svh"

module itt_ctrl
	import itt_pkg::*;
#(
	parameter int unsigned STEP_CYCLES = `ITT_STEP_CYCLES
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic [`ITT_ADDR_W-1:0] addr_i,
	input wire logic [7:0] wr_data_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rd_data_o,
	input wire logic timer_start_i,
	input wire logic [4:0] tx_queue_space_i,
	input wire logic underrun_abort_i,
	input wire logic dchan_bit_valid_i,
	input wire logic dchan_bit_i,
	input wire logic rx_eof_i,
	input wire logic rx_full_i,
	input wire logic tx_done_i,
	input wire logic tx_empty_i,
	output logic timer_running_o,
	output logic timeout_o,
	output logic whole_controller_soft_reset_o,
	output logic receiver_soft_reset_o,
	output logic transmitter_soft_reset_o,
	output logic force_bad_crc_o,
	output logic irq_o
);

	localparam logic [23:0] STEP_LAST = 24'(STEP_CYCLES - 1);

	itt_state_t s_reg;
	itt_state_t s_next;

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		logic wr_timer;
		logic wr_rst;
		logic rd_txq;
		logic [5:0] ev;
		logic [5:0] clr;
		wr_timer = wr_i && addr_i == `ITT_OFS_TIMER;
		wr_rst = wr_i && addr_i == `ITT_OFS_RESET;
		rd_txq = rd_i && addr_i == `ITT_OFS_TXQ;
		s_next = s_reg;
		s_next.timeout = 1'b0;

		// soft reset strobes are one cycle wide
		s_next.whole_rst = wr_rst && wr_data_i[`ITT_RST_WHOLE_BIT];
		s_next.rx_rst = wr_rst && wr_data_i[`ITT_RST_RX_BIT];
		s_next.tx_rst = wr_rst && wr_data_i[`ITT_RST_TX_BIT];
		if (wr_rst) begin
			// bits 5-7 have no storage
			s_next.force_bad_crc = wr_data_i[`ITT_RST_BAD_CRC_BIT];
		end

		// timer configuration, untouched by soft resets
		if (wr_timer) begin
			s_next.interval = wr_data_i[3:0];
			if (wr_data_i[7:4] == `ITT_USAGE_PROG ||
					wr_data_i[7:4] == `ITT_USAGE_OFF) begin
				s_next.usage = wr_data_i[7:4];
			end
		end

		// timer
		unique case (s_reg.tmr_state)
			ITT_TMR_IDLE: begin
				if (timer_start_i && s_reg.usage == `ITT_USAGE_PROG) begin
					s_next.tmr_state = ITT_TMR_RUN;
					s_next.prescale = 24'h000000;
					s_next.steps_left = {1'b0, s_reg.interval} + 5'h01;
				end
			end
			ITT_TMR_RUN: begin
				if (s_reg.usage == `ITT_USAGE_OFF) begin
					s_next.tmr_state = ITT_TMR_IDLE;
				end else if (timer_start_i) begin
					s_next.prescale = 24'h000000;
					s_next.steps_left = {1'b0, s_reg.interval} + 5'h01;
				end else if (s_reg.prescale == STEP_LAST) begin
					s_next.prescale = 24'h000000;
					if (s_reg.steps_left == 5'h01) begin
						s_next.tmr_state = ITT_TMR_IDLE;
						s_next.timeout = 1'b1;
					end else begin
						s_next.steps_left = s_reg.steps_left - 5'h01;
					end
				end else begin
					s_next.prescale = s_reg.prescale + 24'h000001;
				end
			end
		endcase

		// consecutive ones on the D channel, saturating
		if (s_reg.whole_rst) begin
			s_next.prio_count = 4'h0;
		end else if (dchan_bit_valid_i) begin
			if (!dchan_bit_i) begin
				s_next.prio_count = 4'h0;
			end else if (s_reg.prio_count != `ITT_PRIO_MAX) begin
				s_next.prio_count = s_reg.prio_count + 4'h1;
			end
		end

		// underrun flag: cleared by a read, a whole controller reset or a transmitter reset, set wins
		if (rd_txq || s_reg.whole_rst || s_reg.tx_rst) begin
			s_next.underrun_abort_flag = 1'b0;
		end
		if (underrun_abort_i) begin
			s_next.underrun_abort_flag = 1'b1;
		end

		// sticky interrupt status
		ev = 6'h00;
		ev[`ITT_IRQ_TIMEOUT_BIT] = s_reg.timeout;
		ev[`ITT_IRQ_UNDERRUN_BIT] = underrun_abort_i;
		ev[`ITT_IRQ_RX_EOF_BIT] = rx_eof_i;
		ev[`ITT_IRQ_RX_FULL_BIT] = rx_full_i;
		ev[`ITT_IRQ_TX_DONE_BIT] = tx_done_i;
		ev[`ITT_IRQ_TX_EMPTY_BIT] = tx_empty_i;
		clr = 6'h00;
		if (wr_i && addr_i == `ITT_OFS_IRQ_STATUS) begin
			clr = wr_data_i[5:0];
		end
		if (s_reg.rx_rst || s_reg.whole_rst) begin
			clr[`ITT_IRQ_RX_EOF_BIT] = 1'b1;
			clr[`ITT_IRQ_RX_FULL_BIT] = 1'b1;
		end
		if (s_reg.tx_rst || s_reg.whole_rst) begin
			clr[`ITT_IRQ_TX_DONE_BIT] = 1'b1;
			clr[`ITT_IRQ_TX_EMPTY_BIT] = 1'b1;
			clr[`ITT_IRQ_UNDERRUN_BIT] = 1'b1;
		end
		s_next.irq_status = (s_reg.irq_status & ~clr) | ev;
		if (wr_i && addr_i == `ITT_OFS_IRQ_MASK) begin
			s_next.irq_mask = wr_data_i[5:0];
		end
		s_next.irq = |(s_next.irq_status & s_next.irq_mask);

		// read data stands only in the cycle after the strobe
		s_next.rd_data = 8'h00;
		if (rd_i) begin
			unique case (addr_i)
				`ITT_OFS_IRQ_STATUS: s_next.rd_data = {2'h0, s_reg.irq_status};
				`ITT_OFS_IRQ_MASK: s_next.rd_data = {2'h0, s_reg.irq_mask};
				`ITT_OFS_TIMER: s_next.rd_data = {s_reg.usage, s_reg.interval};
				`ITT_OFS_TXQ: begin
					s_next.rd_data = {2'h0, s_reg.underrun_abort_flag,
						tx_queue_space_i};
				end
				`ITT_OFS_RESET: begin
					s_next.rd_data = {3'h0, s_reg.force_bad_crc,
						s_reg.prio_count};
				end
				default: s_next.rd_data = 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// state register, reset as a whole only by the hardware reset; soft resets clear some fields
	// ------------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			s_reg.tmr_state <= ITT_TMR_IDLE;
			s_reg.interval <= `ITT_INTERVAL_RESET;
			s_reg.usage <= `ITT_USAGE_PROG;
			s_reg.prescale <= 24'h000000;
			s_reg.steps_left <= 5'h00;
			s_reg.timeout <= 1'b0;
			s_reg.underrun_abort_flag <= 1'b0;
			s_reg.prio_count <= 4'h0;
			s_reg.force_bad_crc <= 1'b0;
			s_reg.whole_rst <= 1'b0;
			s_reg.rx_rst <= 1'b0;
			s_reg.tx_rst <= 1'b0;
			s_reg.irq_status <= 6'h00;
			s_reg.irq_mask <= `ITT_IRQ_MASK_RESET;
			s_reg.irq <= 1'b0;
			s_reg.rd_data <= 8'h00;
		end else begin
			s_reg <= s_next;
		end
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign rd_data_o = s_reg.rd_data;
	assign timer_running_o = s_reg.tmr_state == ITT_TMR_RUN;
	assign timeout_o = s_reg.timeout;
	assign whole_controller_soft_reset_o = s_reg.whole_rst;
	assign receiver_soft_reset_o = s_reg.rx_rst;
	assign transmitter_soft_reset_o = s_reg.tx_rst;
	assign force_bad_crc_o = s_reg.force_bad_crc;
	assign irq_o = s_reg.irq;

endmodule

// File: itt_dchan_src.sv
// D-channel bit source standing in for the line side
module itt_dchan_src (
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic [4:0] ones_i,
	output logic valid_o,
	output logic bit_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [4:0] n = 5'h00;
	initial valid_o = 1'b0;
	initial bit_o = 1'b0;
	// one zero bit, then ones_i one bits; the idle line toggles
	always @(posedge clk_i) begin
		valid_o <= go_i || n != 5'h00;
		if (go_i) begin
			n <= ones_i;
			bit_o <= 1'b0;
		end else if (n != 5'h00) begin
			n <= n - 5'h01;
			bit_o <= 1'b1;
		end else
			bit_o <= ~bit_o;
	end
endmodule

// File: itt_ctrl_checker.sv
// port assertions for the timer and HDLC control slice
module itt_ctrl_checker #(
	parameter int unsigned STEP_CYCLES = 4
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wr_data_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [7:0] rd_data_o,
	input wire logic [4:0] tx_queue_space_i,
	input wire logic underrun_abort_i,
	input wire logic timer_running_o,
	input wire logic timeout_o,
	input wire logic whole_controller_soft_reset_o,
	input wire logic receiver_soft_reset_o,
	input wire logic transmitter_soft_reset_o,
	input wire logic force_bad_crc_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	logic w15;
	logic r14;
	assign w15 = wr_i && addr_i == 4'hf;
	assign r14 = rd_i && addr_i == 4'he;
	property p_whole; w15 && wr_data_i[0] |=> whole_controller_soft_reset_o;
	endproperty
	a_whole: assert property (p_whole) else $error("no whole reset");
	property p_rx; w15 && wr_data_i[1] |=> receiver_soft_reset_o; endproperty
	a_rx: assert property (p_rx) else $error("no rx reset");
	property p_tx; w15 && wr_data_i[2] |=> transmitter_soft_reset_o;
	endproperty
	a_tx: assert property (p_tx) else $error("no tx reset");
	property p_txsrc; $rose(transmitter_soft_reset_o) |-> $past(w15);
	endproperty
	a_txsrc: assert property (p_txsrc) else $error("stray tx reset");
	property p_crc; w15 |=> force_bad_crc_o == $past(wr_data_i[4]);
	endproperty
	a_crc: assert property (p_crc) else $error("bad crc bit wrong");
	property p_space;
		r14 |=> rd_data_o[4:0] == $past(tx_queue_space_i) && !rd_data_o[7:6];
	endproperty
	a_space: assert property (p_space) else $error("space wrong");
	property p_clr;
		r14 && !underrun_abort_i ##1 r14 && !underrun_abort_i |=> !rd_data_o[5];
	endproperty
	a_clr: assert property (p_clr) else $error("flag kept");
	property p_tmo; timeout_o |-> $past(timer_running_o); endproperty
	a_tmo: assert property (p_tmo) else $error("timeout while idle");
endmodule
bind itt_ctrl itt_ctrl_checker #(.STEP_CYCLES(STEP_CYCLES)) chk_inst (
	.clk_i, .srst_i, .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o,
	.tx_queue_space_i, .underrun_abort_i, .timer_running_o, .timeout_o,
	.whole_controller_soft_reset_o, .receiver_soft_reset_o,
	.transmitter_soft_reset_o, .force_bad_crc_o
);

// File: test_itt_ctrl.sv
// self-checking bench for the register slice
module test_itt_ctrl;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i, srst_i = 1, wr_i = 0, rd_i = 0, ts = 0, ua = 0, eof = 0;
	logic go = 0, dv, db, irq_o, tmo;
	logic [3:0] addr_i = 0;
	logic [7:0] wd = 0, rd_data_o, v;
	logic [4:0] ones = 0;
	int failures = 0, n_compared = 0, cyc = 0, n0, n1;
	logic [23:0] rows [7] = '{24'h0d6060, 24'h0d3161, 24'h01ff3f,
		24'h05ff00, 24'h0f0800, 24'h0f1010, 24'h0d2a2a};
	itt_ctrl #(.STEP_CYCLES(4)) itt_ctrl_inst (.clk_i, .srst_i, .addr_i,
		.wr_data_i(wd), .wr_i, .rd_i, .rd_data_o, .timer_start_i(ts),
		.tx_queue_space_i(5'h13), .underrun_abort_i(ua),
		.dchan_bit_valid_i(dv), .dchan_bit_i(db), .rx_eof_i(eof),
		.rx_full_i(1'b0), .tx_done_i(1'b0), .tx_empty_i(1'b0),
		.timer_running_o(), .timeout_o(tmo),
		.whole_controller_soft_reset_o(), .receiver_soft_reset_o(),
		.transmitter_soft_reset_o(), .force_bad_crc_o(), .irq_o);
	itt_dchan_src itt_dchan_src_inst (.clk_i, .go_i(go), .ones_i(ones),
		.valid_o(dv), .bit_o(db));
	initial begin
		clk_i = 0;
		forever #4 clk_i = ~clk_i;
	end
	task automatic print_verdict;
		if (failures == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			print_verdict;
		end
	end
	task automatic chk(input string s, input logic [7:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", s, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_i) {addr_i, wd, wr_i} <= {a, d, 1'b1};
		@(posedge clk_i) wr_i <= 0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clk_i) {addr_i, rd_i} <= {a, 1'b1};
		@(posedge clk_i) rd_i <= 0;
		#1 v = rd_data_o;
	endtask
	task automatic w2;
		repeat (2) @(posedge clk_i);
		#1;
	endtask
	task automatic tm(output int n);
		@(posedge clk_i) ts <= 1;
		@(posedge clk_i) ts <= 0;
		n = 0;
		while (tmo !== 1'b1 && n < 200) begin
			@(posedge clk_i);
			#1 n++;
		end
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (6) @(posedge clk_i);
		srst_i <= 0;
		rd(4'hd); chk("timer", v, 8'h2f);
		rd(4'h1); chk("mask", v, 8'h00);
		foreach (rows[i]) begin
			wr(rows[i][19:16], rows[i][15:8]);
			rd(rows[i][19:16]); chk("row", v, rows[i][7:0]);
		end
		wr(4'hd, 8'h20); tm(n0);
		wr(4'hd, 8'h21); tm(n1); chk("step", 8'(n1 - n0), 8'h04);
		wr(4'hd, 8'h2f); tm(n1); chk("long", 8'(n1 - n0), 8'h3c);
		wr(4'hd, 8'h60); tm(n1); chk("off", 8'(n1), 8'hc8);
		chk("irq", {7'h00, irq_o}, 8'h01);
		wr(4'h1, 8'h00); w2; chk("irq", {7'h00, irq_o}, 8'h00);
		wr(4'h1, 8'h01); w2; chk("irq", {7'h00, irq_o}, 8'h01);
		wr(4'h0, 8'h01); w2; chk("irq", {7'h00, irq_o}, 8'h00);
		@(posedge clk_i) ua <= 1;
		@(posedge clk_i) ua <= 0;
		rd(4'he); chk("txq", v, 8'h33);
		rd(4'he); chk("txq", v, 8'h13);
		@(posedge clk_i) ua <= 1;
		@(posedge clk_i) ua <= 0;
		wr(4'hf, 8'h04); w2; rd(4'he); chk("txq", v, 8'h13);
		@(posedge clk_i) eof <= 1;
		@(posedge clk_i) eof <= 0;
		rd(4'h0); chk("stat", v, 8'h04);
		wr(4'hf, 8'h02); w2; rd(4'h0); chk("stat", v, 8'h00);
		@(posedge clk_i) {go, ones} <= {1'b1, 5'h14};
		@(posedge clk_i) go <= 0;
		repeat (25) @(posedge clk_i);
		rd(4'hf); chk("prio", v, 8'h0f);
		wr(4'hf, 8'h01); w2; rd(4'hf); chk("prio", v, 8'h00);
		rd(4'hd); chk("timer", v, 8'h60);
		@(posedge clk_i) {go, ones} <= {1'b1, 5'h03};
		@(posedge clk_i) go <= 0;
		repeat (6) @(posedge clk_i);
		rd(4'hf); chk("prio", v, 8'h03);
		print_verdict;
	end
endmodule
